// ### dv/dsc_motor_model.sv
// Motor model: run state and torque estimate
`timescale 1ns/1ps
`default_nettype none
module dsc_motor_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run_cmd,
	input wire logic signed [15:0] load,
	output logic running,
	output logic signed [15:0] torque_est
);
	// ============================================================
	// Plant: torque follows load one cycle late, none when stopped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			running <= 1'b0;
			torque_est <= 16'sh0000;
		end
		else
		begin
			running <= run_cmd;
			torque_est <= run_cmd ? load : 16'sh0000;
		end
	end
endmodule // dsc_motor_model
`default_nettype wire

// ### dv/dsc_top_tb.sv
// Testbench for droop speed control: setting gate and droop output
`timescale 1ns/1ps
`default_nettype none
module dsc_top_tb;
	import dsc_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, run_cmd, running, group_wr_grant;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] speed_ref, max_freq, speed_ref_out;
	logic signed [15:0] torque_est, load;
	logic [5:0] group_change_ok;
	logic [2:0] group_wr_id;
	int errors, check_count;

	dsc_top #(.RW(16), .TICK_CYC(10)) dsc_top_inst (.clk(clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.running(running), .speed_ref(speed_ref), .max_freq(max_freq),
		.torque_est(torque_est), .speed_ref_out(speed_ref_out),
		.group_change_ok(group_change_ok),
		.group_wr_grant(group_wr_grant), .group_wr_id(group_wr_id));
	dsc_motor_model dsc_motor_model_inst (.clk(clk), .rst_n(rst_n),
		.run_cmd(run_cmd), .load(load), .running(running),
		.torque_est(torque_est));

	// ============================================================
	// Clock, bus tasks, checks
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Expected permission bits, bit 0 droop up to bit 5 overload
	function automatic logic [31:0] perm(input int m);
		return {26'h0, m != 0, m == 1 || m == 3, m >= 2,
			m == 1 || m == 3, m == 3, m == 3};
	endfunction

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog: whole run needs well under 10000 cycles
	initial
	begin
		#(40 * 20000);
		errors++;
		wrap_up;
	end

	// ============================================================
	// Tests
	initial
	begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		run_cmd = 1'b0;
		load = 16'sh4000;
		speed_ref = 16'h8000;
		max_freq = 16'h1000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(DSC_ADDR_GAIN, d); check(d, 32'h0000_0000);
		rd(DSC_ADDR_FTIME, d); check(d, 32'h0000_0005);
		// Gain refused outside flux mode, reject flag sticky then cleared
		wr(DSC_ADDR_GAIN, 32'h0000_0010);
		rd(DSC_ADDR_GAIN, d); check(d, 32'h0000_0000);
		rd(DSC_ADDR_STATUS, d); check(d[1], 1'b1);
		rd(DSC_ADDR_STATUS, d); check(d[1], 1'b0);
		rd(8'h40, d); check(d, 32'h0000_0000);
		$display("test reset_and_refusal done");
		for (int m = 0; m < 4; m++)
		begin
			wr(DSC_ADDR_MODE, m);
			#1 check(group_change_ok, perm(m));
			rd(DSC_ADDR_GWRITE, d); check(d, perm(m));
			wr(DSC_ADDR_GWRITE, DSC_GRP_TORQUE_LIM);
			#1 check(group_wr_grant, m >= 2);
			wr(DSC_ADDR_GWRITE, DSC_GRP_ENC_CARD);
			#1 check(group_wr_grant, m == 1 || m == 3);
			wr(DSC_ADDR_GWRITE, DSC_GRP_OVERLOAD);
			#1 check(group_wr_grant, m != 0);
			check(group_wr_id, DSC_GRP_OVERLOAD);
		end
		// Id past the table is refused and flags a reject
		rd(DSC_ADDR_STATUS, d); check(d[1], 1'b1);
		wr(DSC_ADDR_GWRITE, 32'h0000_0006);
		#1 check(group_wr_grant, 1'b0);
		check(group_wr_id, 3'h6);
		rd(DSC_ADDR_STATUS, d); check(d[1], 1'b1);
		$display("test permission_table done");
		@(posedge clk);
		run_cmd <= 1'b1;
		repeat (30) @(posedge clk);
		#1 check(speed_ref_out, 16'h8000);
		wr(DSC_ADDR_MODE, 32'h0000_0000);
		rd(DSC_ADDR_MODE, d); check(d[1:0], 2'h3);
		// Range edges while running
		wr(DSC_ADDR_FTIME, 32'h0000_0002);
		rd(DSC_ADDR_FTIME, d); check(d, 32'h0000_0005);
		wr(DSC_ADDR_FTIME, 32'h0000_0003);
		rd(DSC_ADDR_FTIME, d); check(d, 32'h0000_0003);
		wr(DSC_ADDR_GAIN, 32'h0000_03e9);
		rd(DSC_ADDR_GAIN, d); check(d, 32'h0000_0000);
		wr(DSC_ADDR_GAIN, 32'h0000_01f4);
		rd(DSC_ADDR_GAIN, d); check(d, 32'h0000_01f4);
		// Half torque at 50 % of 0x1000 settles near 0x0400 of droop
		repeat (3000) @(posedge clk);
		#1 check(speed_ref_out, 16'h7c00);
		rd(DSC_ADDR_CORR, d); check(d, 32'h0000_0400);
		rd(DSC_ADDR_STATUS, d); check(d[0], 1'b1);
		$display("test droop_settle done");
		// Zero gain drops the loaded correction at the next tick
		wr(DSC_ADDR_GAIN, 32'h0000_0000);
		repeat (30) @(posedge clk);
		#1 check(speed_ref_out, 16'h8000);
		wr(DSC_ADDR_GAIN, 32'h0000_03e8);
		load <= -16'sh4000;
		repeat (3000) @(posedge clk);
		#1 check(speed_ref_out, 16'h8000);
		rd(DSC_ADDR_CORR, d); check(d, 32'h0000_0000);
		$display("test gain_zero_and_regen done");
		wrap_up;
	end
endmodule // dsc_top_tb
`default_nettype wire

// ### rtl/dsc_lag.sv
// First-order lag filter used on the droop term
`timescale 1ns/1ps
`default_nettype none
module dsc_lag
#(
	parameter int W = 24
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [W-1:0] target,
	input wire logic [15:0] tau_ticks,
	output logic [W-1:0] y
);
	import dsc_pkg::*;

	// ============================================================
	// Lag update: y += (target - y) / tau
	logic signed [W:0] diff;
	logic signed [W:0] step;
	logic [W-1:0] y_reg;
	logic [W-1:0] y_next;

	assign diff = $signed({1'b0, target}) - $signed({1'b0, y_reg});
	assign step = (tau_ticks == 16'h0000) ? diff :
		diff / $signed({{(W-16){1'b0}}, 1'b0, tau_ticks});
	// Small step would stall short of target; force one lsb of motion
	assign y_next = (step == '0 && diff != '0) ?
		((diff > 0) ? y_reg + 1'b1 : y_reg - 1'b1) :
		W'($signed({1'b0, y_reg}) + step);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			y_reg <= '0;
		else if (tick)
			y_reg <= y_next;
	end

	assign y = y_reg;
endmodule // dsc_lag
`default_nettype wire

// ### rtl/dsc_pkg.sv
// Package: constants, register map and types for droop speed control
package dsc_pkg;

	// ============================================================
	// Control modes
	typedef enum logic [1:0]
	{
		DSC_MODE_VF = 2'b00,
		DSC_MODE_VF_ENC = 2'b01,
		DSC_MODE_OLV = 2'b10,
		DSC_MODE_FLUX = 2'b11
	} dsc_mode_t;

	// ============================================================
	// Setting groups (index into permission table)
	localparam int DSC_NGROUPS = 6;
	localparam int DSC_GRP_W = 3;
	localparam logic [2:0] DSC_GRP_DROOP = 3'h0;
	localparam logic [2:0] DSC_GRP_TORQUE_CTRL = 3'h1;
	localparam logic [2:0] DSC_GRP_SPEED_TUNE = 3'h2;
	localparam logic [2:0] DSC_GRP_TORQUE_LIM = 3'h3;
	localparam logic [2:0] DSC_GRP_ENC_CARD = 3'h4;
	localparam logic [2:0] DSC_GRP_OVERLOAD = 3'h5;

	// Permission bits per group, bit index = mode code
	localparam logic [3:0] DSC_PERM_DROOP = 4'h8;
	localparam logic [3:0] DSC_PERM_TORQUE_CTRL = 4'h8;
	localparam logic [3:0] DSC_PERM_SPEED_TUNE = 4'ha;
	localparam logic [3:0] DSC_PERM_TORQUE_LIM = 4'hc;
	localparam logic [3:0] DSC_PERM_ENC_CARD = 4'ha;
	localparam logic [3:0] DSC_PERM_OVERLOAD = 4'he;

	// ============================================================
	// Register map (byte addresses)
	localparam int DSC_AW = 8;
	localparam logic [7:0] DSC_ADDR_GAIN = 8'h00;
	localparam logic [7:0] DSC_ADDR_FTIME = 8'h04;
	localparam logic [7:0] DSC_ADDR_MODE = 8'h08;
	localparam logic [7:0] DSC_ADDR_STATUS = 8'h0c;
	localparam logic [7:0] DSC_ADDR_CORR = 8'h10;
	localparam logic [7:0] DSC_ADDR_GWRITE = 8'h14;

	// Gain in 0.1 %, filter time in 10 ms
	localparam logic [15:0] DSC_GAIN_RST = 16'h0000;
	localparam logic [15:0] DSC_GAIN_MAX = 16'h03e8;
	localparam logic [15:0] DSC_FTIME_RST = 16'h0005;
	localparam logic [15:0] DSC_FTIME_MIN = 16'h0003;
	localparam logic [15:0] DSC_FTIME_MAX = 16'h00c8;

	// Status bit positions
	localparam int DSC_ST_ACTIVE = 0;
	localparam int DSC_ST_REJECT = 1;

	// ============================================================
	// Timing: control tick
	localparam int DSC_CLK_HZ = 25000000;
	localparam int DSC_TICK_US = 1000;
	localparam int DSC_TICK_CYC = DSC_CLK_HZ / 1000000 * DSC_TICK_US;
	localparam int DSC_TICKS_PER_10MS = 10;

	// Bus write carrier
	typedef struct packed
	{
		logic [7:0] addr;
		logic [31:0] data;
	} dsc_wr_t;

endpackage

// ### rtl/dsc_top.sv
// Droop speed control: reference correction and setting gate
// Overview of operation
// - Droop gain is the slip in percent at max reference and rated torque, 0.0 to 100.0, default 0.0.
// - A droop gain of zero applies no correction to the speed reference.
// - The filter time, 0.03 to 2.00 s, default 0.05 s, sets the lag of the droop term.
// - Gain and filter time writes are accepted and applied while the motor runs.
// - The droop group may be changed only in flux vector mode.
// - Each group carries a per-mode permission table that gates changes.
// - The torque control group may be changed only in flux vector mode.
// - The speed loop tuning group may be changed only in the two encoder modes.
// - The torque limit group may be changed only in open loop and flux vector modes.
// - The encoder card group may be changed only in the two encoder modes.
// - The motor overload group may be changed in every mode but plain volts per hertz.
`timescale 1ns/1ps
`default_nettype none
module dsc_top
#(
	parameter int RW = 16,
	parameter int TICK_CYC = dsc_pkg::DSC_TICK_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dsc_pkg::DSC_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic running,
	input wire logic [RW-1:0] speed_ref,
	input wire logic [RW-1:0] max_freq,
	input wire logic signed [RW-1:0] torque_est,
	output logic [RW-1:0] speed_ref_out,
	output logic [dsc_pkg::DSC_NGROUPS-1:0] group_change_ok,
	output logic group_wr_grant,
	output logic [2:0] group_wr_id
);
	import dsc_pkg::*;

	// ============================================================
	// Tick divider
	logic [15:0] tick_cnt_reg;
	logic tick;
	assign tick = (tick_cnt_reg == 16'(TICK_CYC - 1));
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt_reg <= 16'h0000;
		else
			tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
	end

	// ============================================================
	// Mode and permission table
	dsc_mode_t mode_reg;
	logic [3:0] perm_tab [DSC_NGROUPS];
	assign perm_tab[0] = DSC_PERM_DROOP;
	assign perm_tab[1] = DSC_PERM_TORQUE_CTRL;
	assign perm_tab[2] = DSC_PERM_SPEED_TUNE;
	assign perm_tab[3] = DSC_PERM_TORQUE_LIM;
	assign perm_tab[4] = DSC_PERM_ENC_CARD;
	assign perm_tab[5] = DSC_PERM_OVERLOAD;

	genvar g;
	generate
		for (g = 0; g < DSC_NGROUPS; g++)
		begin : g_perm
			assign group_change_ok[g] = perm_tab[g][mode_reg];
		end
	endgenerate

	// ============================================================
	// Bus decode
	dsc_wr_t wr;
	assign wr = '{addr: reg_addr, data: reg_wdata};
	logic wr_gain;
	logic wr_ftime;
	logic wr_mode;
	logic wr_grp;
	logic droop_ok;
	assign droop_ok = group_change_ok[DSC_GRP_DROOP];
	assign wr_gain = reg_wr && (wr.addr == DSC_ADDR_GAIN);
	assign wr_ftime = reg_wr && (wr.addr == DSC_ADDR_FTIME);
	assign wr_mode = reg_wr && (wr.addr == DSC_ADDR_MODE);
	assign wr_grp = reg_wr && (wr.addr == DSC_ADDR_GWRITE);

	logic grp_valid;
	logic grp_ok;
	assign grp_valid = wr.data[2:0] < 3'(DSC_NGROUPS);
	assign grp_ok = grp_valid && group_change_ok[wr.data[2:0]];

	// ============================================================
	// Settings, no run interlock so writes land mid run
	logic [15:0] gain_reg;
	logic [15:0] ftime_reg;
	logic [15:0] gain_in;
	logic [15:0] ftime_in;
	logic gain_range_ok;
	logic ftime_range_ok;
	assign gain_in = wr.data[15:0];
	assign ftime_in = wr.data[15:0];
	assign gain_range_ok = (gain_in <= DSC_GAIN_MAX);
	// Filter time range 0.03 to 2.00
	assign ftime_range_ok = (ftime_in >= DSC_FTIME_MIN) &&
		(ftime_in <= DSC_FTIME_MAX);

	logic gain_take;
	logic ftime_take;
	// Accept while running, gated by mode
	assign gain_take = wr_gain && droop_ok && gain_range_ok;
	assign ftime_take = wr_ftime && droop_ok && ftime_range_ok;

	logic reject_set;
	assign reject_set = (wr_gain && !gain_take) ||
		(wr_ftime && !ftime_take) || (wr_grp && !grp_ok);

	logic reject_reg;
	logic [7:0] group_wr_id_reg;
	logic grant_reg;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gain_reg <= DSC_GAIN_RST;
			ftime_reg <= DSC_FTIME_RST;
			mode_reg <= DSC_MODE_VF;
			reject_reg <= 1'b0;
			grant_reg <= 1'b0;
			group_wr_id_reg <= 8'h00;
		end
		else
		begin
			if (gain_take)
				gain_reg <= gain_in;
			if (ftime_take)
				ftime_reg <= ftime_in;
			// Mode change only while stopped
			if (wr_mode && !running)
				mode_reg <= dsc_mode_t'(wr.data[1:0]);
			// Set wins over read-to-clear
			if (reject_set)
				reject_reg <= 1'b1;
			else if (reg_rd && reg_addr == DSC_ADDR_STATUS)
				reject_reg <= 1'b0;
			grant_reg <= wr_grp && grp_ok;
			if (wr_grp)
				group_wr_id_reg <= {5'h00, wr.data[2:0]};
		end
	end
	assign group_wr_grant = grant_reg;
	assign group_wr_id = group_wr_id_reg[2:0];

	// ============================================================
	// Droop term
	logic [RW-1:0] tq_mag;
	assign tq_mag = torque_est[RW-1] ? RW'(0) : RW'(torque_est);
	logic [RW+31:0] prod;
	logic [23:0] target;
	// Torque times gain times max freq, per mille of rated
	assign prod = tq_mag * gain_reg * max_freq;
	// Torque est full scale 2^(RW-1) = rated; gain lsb 0.1 %
	assign target = 24'((prod >> (RW - 1)) / 1000);

	logic [15:0] tau_ticks;
	// Filter time to ticks, 10 ms units
	assign tau_ticks = 16'(ftime_reg * DSC_TICKS_PER_10MS);

	logic [23:0] droop_f;
	dsc_lag #(.W(24)) u_lag
	(
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.target(target),
		.tau_ticks(tau_ticks),
		.y(droop_f)
	);

	logic [RW-1:0] ref_reg;
	logic [RW-1:0] ref_next;
	logic [24:0] ref_diff;
	assign ref_diff = {9'h000, speed_ref} - {1'b0, droop_f};
	// Subtract on each tick, clamp at zero
	assign ref_next = (gain_reg == 16'h0000) ? speed_ref :
		(ref_diff[24] ? RW'(0) : RW'(ref_diff));
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ref_reg <= '0;
		else if (tick)
			ref_reg <= ref_next;
	end
	assign speed_ref_out = ref_reg;

	// ============================================================
	// Read mux
	logic [31:0] rd_mux;
	logic [31:0] rdata_reg;
	assign rd_mux =
		(reg_addr == DSC_ADDR_GAIN) ? {16'h0000, gain_reg} :
		(reg_addr == DSC_ADDR_FTIME) ? {16'h0000, ftime_reg} :
		(reg_addr == DSC_ADDR_MODE) ? {30'h0000_0000, mode_reg} :
		(reg_addr == DSC_ADDR_STATUS) ? {30'h0000_0000, reject_reg,
			gain_reg != 16'h0000} :
		(reg_addr == DSC_ADDR_CORR) ? {8'h00, droop_f} :
		(reg_addr == DSC_ADDR_GWRITE) ? {26'h000_0000,
			group_change_ok} :
		32'h0000_0000;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
	end
	assign reg_rdata = rdata_reg;

	// ============================================================
	// Checks
	droop_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_gain && mode_reg != DSC_MODE_FLUX) |=> $stable(gain_reg))
		else $error("droop gain changed outside flux vector");
	gain_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_gain && running && mode_reg == DSC_MODE_FLUX && gain_in <= 16'h03e8)
		|=> gain_reg == $past(gain_in))
		else $error("gain write lost while running");
	gain_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		gain_reg <= 16'h03e8)
		else $error("gain beyond 100 percent");
	ftime_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		ftime_reg >= 16'h0003 && ftime_reg <= 16'h00c8)
		else $error("filter time out of range");
	zero_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && gain_reg == 16'h0000) |=> speed_ref_out == $past(speed_ref))
		else $error("correction applied at zero gain");
	torque_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		group_change_ok[1] == (mode_reg == DSC_MODE_FLUX))
		else $error("torque control gate wrong");
	tune_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		group_change_ok[2] == mode_reg[0])
		else $error("speed tuning gate wrong");
	limit_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		group_change_ok[3] == mode_reg[1])
		else $error("torque limit gate wrong");
	enc_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		group_change_ok[4] == mode_reg[0])
		else $error("encoder card gate wrong");
	ovl_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		group_change_ok[5] == (mode_reg != DSC_MODE_VF))
		else $error("overload gate wrong");
	grant_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_grp && !grp_ok) |=> !group_wr_grant && reject_reg)
		else $error("blocked group write granted");
	ref_sub_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && gain_reg != 16'h0000) |=> speed_ref_out <= $past(speed_ref))
		else $error("droop raised reference");

endmodule // dsc_top
`default_nettype wire
